/* File: duart_host_bus_port.sv */
/*
  Host controller that drives the strobe-based 8-bit register port of a
  two-channel UART. A user request names a channel, a register and a
  direction; the controller sequences select, address, data and strobe pins.
  Assumes all device outputs are synchronous to REF_CLK.
*/
`timescale 1ns/1ps

module duart_host_bus_port (
  // Clock and reset
  input  wire logic       REF_CLK,
  input  wire logic       RST,
  // User request
  input  wire logic       REQ_VALID,
  input  wire logic       REQ_WRITE,
  input  wire logic       REQ_CHAN_B,
  input  wire logic [2:0] REQ_ADDR,
  input  wire logic [7:0] REQ_WDATA,
  output logic            REQ_READY,
  output logic            RESP_VALID,
  output logic [7:0]      RESP_RDATA,
  // Device status seen by the user
  output logic [1:0]      IRQ_ENABLED,
  output logic [1:0]      IRQ_PENDING,
  output logic [1:0]      TX_READY,
  output logic [1:0]      RX_READY,
  // Device port pins
  output logic [2:0]      REG_SELECT_LINES,
  input  wire logic [7:0] HOST_BYTE_LINES_IN,
  output logic [7:0]      HOST_BYTE_LINES_OUT,
  output logic            HOST_BYTE_LINES_OE,
  output logic            READ_STROBE_N,
  output logic            WRITE_STROBE_N,
  output logic            CHAN_A_SELECT_N,
  output logic            CHAN_B_SELECT_N,
  // Device status pins
  input  wire logic       CHAN_A_IRQ,
  input  wire logic       CHAN_B_IRQ,
  input  wire logic       CHAN_A_AUX_OUT2_N,
  input  wire logic       CHAN_B_AUX_OUT2_N,
  input  wire logic       CHAN_A_TX_READY_N,
  input  wire logic       CHAN_A_RX_READY_N,
  input  wire logic       CHAN_B_TX_READY_N,
  input  wire logic       CHAN_B_RX_READY_N
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    duart_host_pkg::phase_t             phase;
    logic [duart_host_pkg::CNT_W-1:0]   count;
    logic                               write;
    logic                               chan_b;
    logic [2:0]                         addr;
    logic [7:0]                         wdata;
    logic                               req_ready;
    logic                               resp_valid;
    logic [7:0]                         rdata;
    logic [1:0]                         irq_en;
    logic [1:0]                         irq_pend;
    logic [1:0]                         tx_rdy;
    logic [1:0]                         rx_rdy;
    logic [2:0]                         sel_lines;
    logic [7:0]                         out_byte;
    logic                               oe;
    logic                               rd_n;
    logic                               wr_n;
    logic                               cs_a_n;
    logic                               cs_b_n;
  } state_t;

  state_t st;
  state_t next_st;

  localparam logic [7:0] SETUP_N = 8'(duart_host_pkg::SETUP_CYCLES);
  localparam logic [7:0] STROBE_N = 8'(duart_host_pkg::STROBE_CYCLES);
  localparam logic [7:0] RECOVER_N = 8'(duart_host_pkg::RECOVER_CYCLES);

  // ----------------------------------------------------------------------
  // Per-channel status pins
  // ----------------------------------------------------------------------
  logic [1:0] aux_out2_n;
  logic [1:0] irq_pin;
  logic [1:0] tx_ready_n;
  logic [1:0] rx_ready_n;
  logic [1:0] chan_irq_en;
  logic [1:0] chan_irq_pend;
  logic [1:0] chan_tx_rdy;
  logic [1:0] chan_rx_rdy;

  assign aux_out2_n = {CHAN_B_AUX_OUT2_N, CHAN_A_AUX_OUT2_N};
  assign irq_pin    = {CHAN_B_IRQ, CHAN_A_IRQ};
  assign tx_ready_n = {CHAN_B_TX_READY_N, CHAN_A_TX_READY_N};
  assign rx_ready_n = {CHAN_B_RX_READY_N, CHAN_A_RX_READY_N};

  for (genvar c = 0; c < 2; c++) begin : chan_status
    // Interrupt pin only meaningful when the aux output shows driven mode
    assign chan_irq_en[c]   = ~aux_out2_n[c];
    assign chan_irq_pend[c] = ~aux_out2_n[c] & irq_pin[c];
    assign chan_tx_rdy[c]   = ~tx_ready_n[c];
    assign chan_rx_rdy[c]   = ~rx_ready_n[c];
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.resp_valid = 1'b0;
    next_st.irq_en = chan_irq_en;
    next_st.irq_pend = chan_irq_pend;
    next_st.tx_rdy = chan_tx_rdy;
    next_st.rx_rdy = chan_rx_rdy;
    case (st.phase)
      duart_host_pkg::ST_IDLE: begin
        if (REQ_VALID && st.req_ready) begin
          next_st.req_ready = 1'b0;
          next_st.write = REQ_WRITE;
          next_st.chan_b = REQ_CHAN_B;
          next_st.addr = REQ_ADDR;
          next_st.wdata = REQ_WDATA;
          next_st.sel_lines = REQ_ADDR;
          next_st.cs_a_n = REQ_CHAN_B;
          next_st.cs_b_n = ~REQ_CHAN_B;
          next_st.out_byte = REQ_WDATA;
          next_st.oe = REQ_WRITE;
          next_st.count = SETUP_N;
          next_st.phase = duart_host_pkg::ST_SETUP;
        end
      end
      duart_host_pkg::ST_SETUP: begin
        if (st.count > 8'h01) begin
          next_st.count = st.count - 8'h01;
        end else begin
          next_st.rd_n = st.write;
          next_st.wr_n = ~st.write;
          next_st.count = STROBE_N;
          next_st.phase = duart_host_pkg::ST_STROBE;
        end
      end
      duart_host_pkg::ST_STROBE: begin
        if (st.count > 8'h01) begin
          next_st.count = st.count - 8'h01;
        end else begin
          if (!st.write) begin
            next_st.rdata = HOST_BYTE_LINES_IN;
            next_st.resp_valid = 1'b1;
          end
          next_st.rd_n = 1'b1;
          next_st.wr_n = 1'b1;
          next_st.count = RECOVER_N;
          next_st.phase = duart_host_pkg::ST_RECOVER;
        end
      end
      duart_host_pkg::ST_RECOVER: begin
        // Hold select, address and data one hold period past the strobe rise
        if (st.count > 8'h01) begin
          next_st.count = st.count - 8'h01;
        end else begin
          next_st.oe = 1'b0;
          next_st.cs_a_n = 1'b1;
          next_st.cs_b_n = 1'b1;
          next_st.req_ready = 1'b1;
          next_st.phase = duart_host_pkg::ST_IDLE;
        end
      end
      default: begin
        next_st.phase = duart_host_pkg::ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      st <= '0;
      st.phase <= duart_host_pkg::ST_IDLE;
      st.req_ready <= 1'b1;
      st.rd_n <= 1'b1;
      st.wr_n <= 1'b1;
      st.cs_a_n <= 1'b1;
      st.cs_b_n <= 1'b1;
      st.rdata <= duart_host_pkg::DATA_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign REQ_READY = st.req_ready;
  assign RESP_VALID = st.resp_valid;
  assign RESP_RDATA = st.rdata;
  assign IRQ_ENABLED = st.irq_en;
  assign IRQ_PENDING = st.irq_pend;
  assign TX_READY = st.tx_rdy;
  assign RX_READY = st.rx_rdy;
  assign REG_SELECT_LINES = st.sel_lines;
  assign HOST_BYTE_LINES_OUT = st.out_byte;
  assign HOST_BYTE_LINES_OE = st.oe;
  assign READ_STROBE_N = st.rd_n;
  assign WRITE_STROBE_N = st.wr_n;
  assign CHAN_A_SELECT_N = st.cs_a_n;
  assign CHAN_B_SELECT_N = st.cs_b_n;

endmodule

/* File: duart_host_pkg.sv */
/*
  Constants for the host-side controller of a two-channel UART parallel port.
  Assumes a single 250 MHz clock; the device pins are sampled synchronously.
*/
package duart_host_pkg;

  // ----------------------------------------------------------------------
  // Strobe timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int SETUP_TIME_NS = 8;
  localparam int STROBE_TIME_NS = 40;
  localparam int RECOVER_TIME_NS = 20;
  localparam int SETUP_CYCLES = (SETUP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STROBE_CYCLES = (STROBE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RECOVER_CYCLES = (RECOVER_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 8;

  // ----------------------------------------------------------------------
  // Bus widths and reset values
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // Device register offsets used by the testbench
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] MODEM_CONTROL_OFS = 3'h4;
  localparam int IRQ_ENABLE_BIT = 3;

  typedef enum {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_RECOVER
  } phase_t;

endpackage

/* File: duart_dev_model.sv */
/* Behavioural model of the two-channel UART register port.
   Assumes the host sequences selects, address and strobes. */
`timescale 1ns/1ps
module duart_dev_model (
  // Host bus pins
  input  wire logic [2:0] addr,
  input  wire logic [7:0] bus,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic       sel_a_n,
  input  wire logic       sel_b_n,
  output logic      [7:0] drv,
  // Status sources: irq b, irq a, rx b, tx b, rx a, tx a
  input  wire logic [5:0] src,
  output logic      [1:0] irq,
  output logic      [1:0] aux_n,
  output logic      [1:0] tx_n,
  output logic      [1:0] rx_n
);
  // ----------------------------------------
  // Registers, bus and status pins
  // ----------------------------------------
  logic [7:0] regs [16];
  logic [7:0] keep;
  logic       one_sel;
  logic [3:0] idx;
  initial begin
    foreach (regs[i]) regs[i] = 8'h00;
    keep = 8'h00;
  end
  assign one_sel = sel_a_n ^ sel_b_n;
  assign idx = {~sel_b_n, addr};
  // Released bus shows the inverse of the last byte
  assign drv = (one_sel && !rd_n) ? regs[idx] : ~keep;
  always @(posedge rd_n) keep = regs[idx];
  always @(posedge wr_n) begin
    keep = bus;
    if (one_sel) regs[idx] = bus;
  end
  assign aux_n = {~regs[4'hC][3], ~regs[4'h4][3]};
  // Floating interrupt pin shows the inverse level
  assign irq = {regs[4'hC][3] ? src[5] : ~src[5], regs[4'h4][3] ? src[4] : ~src[4]};
  assign tx_n = ~{src[2], src[0]};
  assign rx_n = ~{src[3], src[1]};
endmodule

/* File: duart_host_bus_port_sva.sv */
/* Checker for the host port pins.
   Bound to every duart_host_bus_port instance. */
`timescale 1ns/1ps
module duart_host_bus_port_sva (
  input wire logic       REF_CLK,
  input wire logic       RST,
  input wire logic       RESP_VALID,
  input wire logic [7:0] RESP_RDATA,
  input wire logic [2:0] REG_SELECT_LINES,
  input wire logic [7:0] HOST_BYTE_LINES_IN,
  input wire logic [7:0] HOST_BYTE_LINES_OUT,
  input wire logic       HOST_BYTE_LINES_OE,
  input wire logic       READ_STROBE_N,
  input wire logic       WRITE_STROBE_N,
  input wire logic       CHAN_A_SELECT_N,
  input wire logic       CHAN_B_SELECT_N
);
  // ----------------------------------------
  // Strobe cycle checks
  // ----------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  sequence s_wr_hold;
    (!WRITE_STROBE_N && $stable(REG_SELECT_LINES) && $stable(HOST_BYTE_LINES_OUT))[*8];
  endsequence
  sequence s_rd_end;
    $rose(READ_STROBE_N);
  endsequence
  one_select_a:
    assert property ((!READ_STROBE_N || !WRITE_STROBE_N) |-> CHAN_A_SELECT_N ^ CHAN_B_SELECT_N)
    else $error("strobe low without exactly one select");
  read_release_a:
    assert property (!READ_STROBE_N |-> !HOST_BYTE_LINES_OE) else $error("host drives during read");
  write_drive_a:
    assert property (!WRITE_STROBE_N |-> HOST_BYTE_LINES_OE) else $error("bus not driven in write");
  write_hold_a:
    assert property ($fell(WRITE_STROBE_N) |-> s_wr_hold) else $error("write cycle not held");
  read_capture_a:
    assert property (s_rd_end |-> RESP_VALID && RESP_RDATA == $past(HOST_BYTE_LINES_IN))
    else $error("read byte not captured at strobe rise");
endmodule
bind duart_host_bus_port duart_host_bus_port_sva duart_host_bus_port_sva_inst (.REF_CLK, .RST,
  .RESP_VALID, .RESP_RDATA, .REG_SELECT_LINES, .HOST_BYTE_LINES_IN, .HOST_BYTE_LINES_OUT,
  .HOST_BYTE_LINES_OE, .READ_STROBE_N, .WRITE_STROBE_N, .CHAN_A_SELECT_N, .CHAN_B_SELECT_N);

/* File: test_duart_host_bus_port.sv */
/* Testbench for duart_host_bus_port with the device model on its pins.
   Assumes the package register offsets. */
`timescale 1ns/1ps
module test_duart_host_bus_port;
  // ----------------------------------------
  // Signals, instances and tasks
  // ----------------------------------------
  logic       REF_CLK = 1'b0, RST = 1'b1, REQ_VALID = 1'b0, REQ_WRITE = 1'b0, REQ_CHAN_B = 1'b0;
  logic [2:0] REQ_ADDR = 3'h0, REG_SELECT_LINES;
  logic [7:0] REQ_WDATA = 8'h00, RESP_RDATA, HOST_BYTE_LINES_OUT, drv;
  logic       REQ_READY, RESP_VALID, HOST_BYTE_LINES_OE, READ_STROBE_N, WRITE_STROBE_N;
  logic       CHAN_A_SELECT_N, CHAN_B_SELECT_N;
  logic [1:0] IRQ_ENABLED, IRQ_PENDING, TX_READY, RX_READY, irq, aux_n, tx_n, rx_n;
  logic [5:0] src = 6'h00;
  wire  [7:0] HOST_BYTE_LINES_IN;
  int         n_mismatch = 0, checks = 0;
  always #2 REF_CLK = ~REF_CLK;
  assign HOST_BYTE_LINES_IN = HOST_BYTE_LINES_OE ? HOST_BYTE_LINES_OUT : drv;
  duart_host_bus_port duart_host_bus_port_inst (.REF_CLK, .RST, .REQ_VALID, .REQ_WRITE,
    .REQ_CHAN_B, .REQ_ADDR, .REQ_WDATA, .REQ_READY, .RESP_VALID, .RESP_RDATA, .IRQ_ENABLED,
    .IRQ_PENDING, .TX_READY, .RX_READY, .REG_SELECT_LINES, .HOST_BYTE_LINES_IN,
    .HOST_BYTE_LINES_OUT, .HOST_BYTE_LINES_OE, .READ_STROBE_N, .WRITE_STROBE_N,
    .CHAN_A_SELECT_N, .CHAN_B_SELECT_N, .CHAN_A_IRQ(irq[0]), .CHAN_B_IRQ(irq[1]),
    .CHAN_A_AUX_OUT2_N(aux_n[0]), .CHAN_B_AUX_OUT2_N(aux_n[1]), .CHAN_A_TX_READY_N(tx_n[0]),
    .CHAN_A_RX_READY_N(rx_n[0]), .CHAN_B_TX_READY_N(tx_n[1]), .CHAN_B_RX_READY_N(rx_n[1]));
  duart_dev_model duart_dev_model_inst (.addr(REG_SELECT_LINES), .bus(HOST_BYTE_LINES_IN),
    .rd_n(READ_STROBE_N), .wr_n(WRITE_STROBE_N), .sel_a_n(CHAN_A_SELECT_N),
    .sel_b_n(CHAN_B_SELECT_N), .drv, .src, .irq, .aux_n, .tx_n, .rx_n);
  task automatic final_report();
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic guard(input int n);
    if (n >= 40) begin
      n_mismatch++;
      final_report();
    end
  endtask
  task automatic xfer(input logic w, b, input logic [2:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    int n;
    n = 0;
    while (REQ_READY !== 1'b1 && n < 40) begin
      @(negedge REF_CLK);
      n++;
    end
    guard(n);
    {REQ_VALID, REQ_WRITE, REQ_CHAN_B, REQ_ADDR, REQ_WDATA} = {1'b1, w, b, a, d};
    @(negedge REF_CLK);
    REQ_VALID = 1'b0;
    n = 0;
    while (!w && RESP_VALID !== 1'b1 && n < 40) begin
      @(negedge REF_CLK);
      n++;
    end
    guard(n);
    q = RESP_RDATA;
  endtask
  task automatic regs_both_chans();
    logic [7:0] q;
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, 1'b0, 3'(i), 8'h10 + 8'(i), q);
      xfer(1'b1, 1'b1, 3'(i), 8'hC0 + 8'(i), q);
    end
    for (int i = 0; i < 8; i++) begin
      xfer(1'b0, 1'b0, 3'(i), 8'h00, q);
      chk("chan a reg", 8'h10 + 8'(i), q);
      xfer(1'b0, 1'b1, 3'(i), 8'h00, q);
      chk("chan b reg", 8'hC0 + 8'(i), q);
    end
  endtask
  task automatic irq_modes();
    logic [7:0] q;
    repeat (24) @(negedge REF_CLK);
    chk("irq enabled", 8'h00, {6'h00, IRQ_ENABLED});
    chk("irq pending", 8'h00, {6'h00, IRQ_PENDING});
    for (int b = 0; b < 2; b++) begin
      xfer(1'b1, 1'(b), duart_host_pkg::MODEM_CONTROL_OFS, 8'h08, q);
      src = 6'h30;
      repeat (24) @(negedge REF_CLK);
      chk("irq enabled", 8'h01 << b | 8'(b), {6'h00, IRQ_ENABLED});
      chk("irq pending", 8'h01 << b | 8'(b), {6'h00, IRQ_PENDING});
    end
  endtask
  task automatic ready_pins();
    for (int i = 0; i < 4; i++) begin
      src[3:0] = 4'h1 << i;
      repeat (4) @(negedge REF_CLK);
      chk("tx ready", {6'h00, src[2], src[0]}, {6'h00, TX_READY});
      chk("rx ready", {6'h00, src[3], src[1]}, {6'h00, RX_READY});
    end
  endtask
  initial begin
    repeat (3) @(posedge REF_CLK);
    @(negedge REF_CLK);
    RST = 1'b0;
    regs_both_chans();
    irq_modes();
    ready_pins();
    final_report();
  end
endmodule
